// ### fpec_flash_ctrl.v
`timescale 1ns/1ps
`include "fpec_defs.vh"
// run-time flash program/erase sequencer with avalon-mm register access
module fpec_flash_ctrl #(
    parameter CNT_W = 24,
    parameter WORD_CYCLES = 24'h000800,
    parameter ROW_CYCLES = 24'h02B38,
    parameter PAGE_CYCLES = 24'h02B38,
    parameter BULK_CYCLES = 24'h005000,
    parameter CFG_CYCLES = 24'h000800
) (
    sys_clk,
    arst_n,
    ce,
    warmRst,
    avs_address,
    avs_read,
    avs_write,
    avs_writedata,
    avs_byteenable,
    avs_readdata,
    avs_waitrequest,
    flashAbort,
    cpuStall,
    flashActive,
    flashErase,
    flashOpCode,
    flashAddr
);
    input wire sys_clk;
    input wire arst_n;
    input wire ce;
    input wire warmRst;
    input wire [`FPEC_ADDR_W-1:0] avs_address;
    input wire avs_read;
    input wire avs_write;
    input wire [31:0] avs_writedata;
    input wire [3:0] avs_byteenable;
    output reg [31:0] avs_readdata;
    output reg avs_waitrequest;
    input wire flashAbort;
    output reg cpuStall;
    output reg flashActive;
    output reg flashErase;
    output reg [3:0] flashOpCode;
    output reg [23:0] flashAddr;

    localparam KS_IDLE = 2'h0;
    localparam KS_FIRST = 2'h1;
    localparam KS_ARMED = 2'h2;

    // classify an erase-select plus operation code
    function [2:0] opClass;
        input erase;
        input [3:0] code;
        begin
            opClass = `FPEC_CLS_UNIMPL;
            if (erase) begin
                case (code) // see [R9]
                    `FPEC_CODE_BULK: opClass = `FPEC_CLS_BULK;
                    `FPEC_CODE_GENSEG: opClass = `FPEC_CLS_BULK;
                    `FPEC_CODE_SECSEG: opClass = `FPEC_CLS_BULK;
                    `FPEC_CODE_PAGE: opClass = `FPEC_CLS_PAGE;
                    `FPEC_CODE_CFG: opClass = `FPEC_CLS_CFG;
                    `FPEC_CODE_WORD: opClass = `FPEC_CLS_NOOP;
                    `FPEC_CODE_ROW: opClass = `FPEC_CLS_NOOP;
                    default: opClass = `FPEC_CLS_UNIMPL; // see [R11]
                endcase
            end else begin
                case (code) // see [R10]
                    `FPEC_CODE_WORD: opClass = `FPEC_CLS_WORD;
                    `FPEC_CODE_ROW: opClass = `FPEC_CLS_ROW;
                    `FPEC_CODE_CFG: opClass = `FPEC_CLS_CFG;
                    `FPEC_CODE_BULK: opClass = `FPEC_CLS_NOOP;
                    `FPEC_CODE_GENSEG: opClass = `FPEC_CLS_NOOP;
                    `FPEC_CODE_SECSEG: opClass = `FPEC_CLS_NOOP;
                    `FPEC_CODE_PAGE: opClass = `FPEC_CLS_NOOP;
                    default: opClass = `FPEC_CLS_UNIMPL; // see [R11]
                endcase
            end
        end
    endfunction

    // control register state; power-on reset only, except the key state, which warm reset also clears
    reg start_q;
    reg allow_q;
    reg fault_q;
    reg erase_q;
    reg [3:0] opCode_q;
    reg [1:0] keyState_q;
    reg [7:0] pagePtr_q;
    reg [15:0] effAddr_q;
    reg ackPending_q;
    reg timerLoad_q;
    reg [CNT_W-1:0] timerValue_q;
    reg immDone_q;

    wire timerBusy;
    wire timerDone;
    wire busAccess = (avs_read | avs_write) & ~ackPending_q;
    // a write lands on the answer edge, the one where the master sees waitrequest low
    wire wrStrobe = avs_write & ackPending_q;
    wire ctrlWr = wrStrobe & (avs_address == `FPEC_IDX_CTRL);
    wire keyWr = wrStrobe & (avs_address == `FPEC_IDX_KEY) & avs_byteenable[0];
    wire startReq = ctrlWr & avs_byteenable[1] & avs_writedata[`FPEC_BIT_START];
    wire opRunning = start_q;

    // next-cycle values of erase select and code as the start write sees them
    wire eraseNew = avs_byteenable[0] ? avs_writedata[`FPEC_BIT_ERASE] : erase_q;
    wire [3:0] opNew = avs_byteenable[0] ? avs_writedata[`FPEC_OP_HI:`FPEC_OP_LO] : opCode_q;
    wire allowNew = avs_byteenable[1] ? avs_writedata[`FPEC_BIT_ALLOW] : allow_q;
    wire [2:0] newClass = opClass(eraseNew, opNew);
    wire launchOk = startReq & ~opRunning & (keyState_q == KS_ARMED) & allowNew; // see [R2] [R6]
    wire launchBad = startReq & ~opRunning & ~launchOk; // see [R21]
    wire launchTimed = launchOk & (newClass != `FPEC_CLS_NOOP) &
        (newClass != `FPEC_CLS_UNIMPL);
    wire launchEmpty = launchOk & ~launchTimed;
    wire abortNow = flashAbort & timerBusy;

    reg [CNT_W-1:0] cyclesNew;

    always @* begin
        case (newClass)
            `FPEC_CLS_WORD: cyclesNew = WORD_CYCLES;
            `FPEC_CLS_ROW: cyclesNew = ROW_CYCLES;
            `FPEC_CLS_PAGE: cyclesNew = PAGE_CYCLES;
            `FPEC_CLS_BULK: cyclesNew = BULK_CYCLES;
            `FPEC_CLS_CFG: cyclesNew = CFG_CYCLES;
            default: cyclesNew = {CNT_W{1'b0}};
        endcase
    end

    fpec_op_timer #(
        .CNT_W(CNT_W)
    ) uTimer (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .load(timerLoad_q),
        .loadValue(timerValue_q),
        .abort(abortNow),
        .busy(timerBusy),
        .done(timerDone)
    );

    // key sequence tracker; any other write breaks the chain
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            keyState_q <= KS_IDLE;
        end else if (ce) begin
            if (warmRst) begin
                keyState_q <= KS_IDLE;
            end else if (keyWr) begin
                if (avs_writedata[7:0] == `FPEC_KEY_FIRST) begin // see [R1]
                    keyState_q <= KS_FIRST;
                end else if (keyState_q == KS_FIRST &&
                        avs_writedata[7:0] == `FPEC_KEY_SECOND) begin
                    keyState_q <= KS_ARMED; // see [R21]
                end else begin
                    keyState_q <= KS_IDLE;
                end
            end else if (wrStrobe) begin
                // arming is used up by the very next write, start or not
                keyState_q <= KS_IDLE; // see [R2]
            end
        end
    end

    // control register; warm reset deliberately not applied here
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin // see [R12]
            start_q <= 1'b0;
            allow_q <= 1'b0;
            fault_q <= 1'b0;
            erase_q <= 1'b0;
            opCode_q <= 4'h0;
            timerLoad_q <= 1'b0;
            timerValue_q <= {CNT_W{1'b0}};
            immDone_q <= 1'b0;
        end else if (ce) begin
            timerLoad_q <= launchTimed;
            timerValue_q <= cyclesNew;
            immDone_q <= launchEmpty;
            // settings are frozen while an operation runs
            if (ctrlWr && !opRunning) begin
                if (avs_byteenable[0]) begin
                    erase_q <= avs_writedata[`FPEC_BIT_ERASE]; // see [R8]
                    opCode_q <= avs_writedata[`FPEC_OP_HI:`FPEC_OP_LO]; // see [R22]
                end
                if (avs_byteenable[1]) begin
                    allow_q <= avs_writedata[`FPEC_BIT_ALLOW]; // see [R6]
                    fault_q <= avs_writedata[`FPEC_BIT_FAULT];
                end
            end
            if (launchOk) begin
                start_q <= 1'b1; // see [R4] [R5]
            end else if (timerDone || immDone_q) begin
                start_q <= 1'b0; // see [R4]
                fault_q <= (immDone_q &
                    (opClass(erase_q, opCode_q) == `FPEC_CLS_UNIMPL)); // see [R7] [R11]
            end else if (abortNow) begin
                start_q <= 1'b0;
            end
            // hardware set wins over a software clear in the same cycle
            if (launchBad || abortNow) begin
                fault_q <= 1'b1; // see [R7] [R21]
            end
        end
    end

    // table page pointer and effective address registers
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pagePtr_q <= 8'h00;
            effAddr_q <= 16'h0000;
        end else if (ce && wrStrobe && !opRunning) begin
            if (avs_address == `FPEC_IDX_PAGE && avs_byteenable[0]) begin
                pagePtr_q <= avs_writedata[7:0];
            end
            if (avs_address == `FPEC_IDX_EA) begin
                if (avs_byteenable[0]) begin
                    effAddr_q[7:0] <= avs_writedata[7:0];
                end
                if (avs_byteenable[1]) begin
                    effAddr_q[15:8] <= avs_writedata[15:8];
                end
            end
        end
    end

    // outputs toward the array and the processor
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpuStall <= 1'b0;
            flashActive <= 1'b0;
            flashErase <= 1'b0;
            flashOpCode <= 4'h0;
            flashAddr <= 24'h000000;
        end else if (ce) begin
            cpuStall <= (start_q & ~timerDone & ~immDone_q & ~abortNow) | launchOk; // see [R13]
            flashActive <= (timerBusy & ~timerDone & ~abortNow) | timerLoad_q;
            if (launchOk) begin
                flashErase <= eraseNew;
                flashOpCode <= opNew;
                flashAddr <= {pagePtr_q, effAddr_q}; // see [R20]
            end
        end
    end

    // bus slave: one wait state, then a single-cycle answer
    reg [31:0] readMux;

    always @* begin
        case (avs_address)
            `FPEC_IDX_CTRL: readMux = {16'h0000, start_q, allow_q, fault_q, 6'h00,
                erase_q, 2'h0, opCode_q}; // see [R22]
            `FPEC_IDX_KEY: readMux = 32'h00000000; // see [R3]
            `FPEC_IDX_PAGE: readMux = {24'h000000, pagePtr_q};
            `FPEC_IDX_EA: readMux = {16'h0000, effAddr_q};
            `FPEC_IDX_STAT: readMux = {27'h0000000, flashActive, cpuStall,
                (keyState_q == KS_ARMED), keyState_q == KS_FIRST, timerBusy};
            default: readMux = 32'h00000000;
        endcase
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ackPending_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
        end else if (ce) begin
            ackPending_q <= busAccess;
            avs_waitrequest <= ~busAccess;
            if (busAccess && avs_read) begin
                avs_readdata <= readMux;
            end
        end
    end
endmodule // fpec_flash_ctrl

// ### fpec_defs.vh
// Function
// [R1] software writes 55h then AAh to the unlock key before any operation
// [R2] no erase or program proceeds without the key sequence just before it
// [R3] key is 8-bit write-only in bits 7..0; whole register reads zero
// [R4] setting control bit 15 launches a self-timed operation, cleared on completion
// [R5] start bit is set-only; writing zero to it does nothing
// [R6] bit 14 clear inhibits every erase and program; set permits them
// [R7] bit 13 flags improper sequences or terminations; cleared by normal completion
// [R8] bit 6 selects erase (one) or program (zero) for the next start
// [R9] erase codes: 1111 bulk, 1101 general, 1100 secure, 0010 page, 0000 config
// [R10] program codes: 0011 word, 0001 row, 0000 config; others do nothing
// [R11] unlisted operation codes are unimplemented and cause no flash activity
// [R12] control bits clear only on power-on reset, not on warm resets
// [R13] processor is stalled for the whole cycle, released as start clears
// [R14] software saves and erases the eight-row page before changing a row
// [R15] page erase uses code 0010 with erase and allow set, page address loaded
// [R16] software loads 64 words into buffers, then selects code 0001, program
// [R17] software repeats loading and row programming until 512 words are rewritten
// [R18] software waits out the programming time before trusting the contents
// [R19] software places two no-operations after the instruction setting start
// [R20] target address is page pointer bits 7..0 above the working effective address
// [R21] arm only on 55h then AAh, start next; unarmed start flags and is ignored
// [R22] control bits 12..7 and 5..4 ignore writes and read zero
`ifndef FPEC_DEFS_VH
`define FPEC_DEFS_VH

`define FPEC_ADDR_W 3
`define FPEC_IDX_CTRL 3'h0
`define FPEC_IDX_KEY 3'h1
`define FPEC_IDX_PAGE 3'h2
`define FPEC_IDX_EA 3'h3
`define FPEC_IDX_STAT 3'h4

`define FPEC_BIT_START 15
`define FPEC_BIT_ALLOW 14
`define FPEC_BIT_FAULT 13
`define FPEC_BIT_ERASE 6
`define FPEC_OP_HI 3
`define FPEC_OP_LO 0

`define FPEC_KEY_FIRST 8'h55
`define FPEC_KEY_SECOND 8'hAA

`define FPEC_CODE_BULK 4'hF
`define FPEC_CODE_GENSEG 4'hD
`define FPEC_CODE_SECSEG 4'hC
`define FPEC_CODE_WORD 4'h3
`define FPEC_CODE_PAGE 4'h2
`define FPEC_CODE_ROW 4'h1
`define FPEC_CODE_CFG 4'h0

`define FPEC_CLS_UNIMPL 3'h0
`define FPEC_CLS_NOOP 3'h1
`define FPEC_CLS_WORD 3'h2
`define FPEC_CLS_ROW 3'h3
`define FPEC_CLS_PAGE 3'h4
`define FPEC_CLS_BULK 3'h5
`define FPEC_CLS_CFG 3'h6

`endif

// ### fpec_op_timer.v
`timescale 1ns/1ps
// down-counter that times one flash operation
module fpec_op_timer #(
    parameter CNT_W = 24
) (
    sys_clk,
    arst_n,
    ce,
    load,
    loadValue,
    abort,
    busy,
    done
);
    input wire sys_clk;
    input wire arst_n;
    input wire ce;
    input wire load;
    input wire [CNT_W-1:0] loadValue;
    input wire abort;
    output reg busy;
    output reg done;

    reg [CNT_W-1:0] count_q;

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= {CNT_W{1'b0}};
            busy <= 1'b0;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
                count_q <= {CNT_W{1'b0}};
            end else if (load) begin
                busy <= 1'b1;
                count_q <= loadValue;
            end else if (busy) begin
                if (count_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    count_q <= {CNT_W{1'b0}};
                end else begin
                    count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // fpec_op_timer

// ### fpec_flash_ctrl_props.sv
`timescale 1ns/1ps
`include "fpec_defs.vh"
module fpec_flash_ctrl_props (
    input wire sys_clk,
    input wire arst_n,
    input wire [`FPEC_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire flashAbort,
    input wire cpuStall,
    input wire flashActive,
    input wire flashErase,
    input wire [3:0] flashOpCode,
    input wire [23:0] flashAddr
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);
    // a read is taken while waitrequest is still high; data stand one edge later
    wire rdTaken = avs_read && avs_waitrequest;
    start_cause_a: assert property ($rose(cpuStall) |-> $past(avs_write
        && avs_address == `FPEC_IDX_CTRL && avs_writedata[15] && avs_writedata[14]))
        else $error("stall rose without an enabled start write");
    op_legal_a: assert property ($rose(flashActive) |-> (flashErase ?
        flashOpCode inside {4'hF, 4'hD, 4'hC, 4'h2, 4'h0} : flashOpCode inside {4'h3, 4'h1, 4'h0}))
        else $error("flash cycle for a code that does nothing");
    stall_hold_a: assert property ($rose(flashActive) |-> cpuStall && $past(cpuStall))
        else $error("flash cycle began without stall");
    stall_drop_a: assert property ($fell(flashActive) |-> !cpuStall)
        else $error("stall outlived the flash cycle");
    latch_hold_a: assert property (flashActive && $past(flashActive) |->
        $stable(flashErase) && $stable(flashOpCode) && $stable(flashAddr))
        else $error("operation outputs moved mid cycle");
    key_zero_a: assert property (rdTaken && avs_address == `FPEC_IDX_KEY |=>
        !avs_waitrequest && avs_readdata == 32'h0)
        else $error("key register read back nonzero");
    ctrl_gaps_a: assert property (rdTaken && avs_address == `FPEC_IDX_CTRL |=>
        avs_readdata[31:16] == 16'h0 && avs_readdata[12:7] == 6'h0 && avs_readdata[5:4] == 2'h0)
        else $error("unused control bits read nonzero");
    abort_end_a: assert property (flashAbort && flashActive |->
        ##[1:3] (!flashActive && !cpuStall))
        else $error("abort did not end the cycle");
    cover property ($rose(flashActive) && flashErase);
    cover property ($rose(flashActive) && !flashErase);
    cover property (flashAbort && flashActive);
endmodule // fpec_flash_ctrl_props

bind fpec_flash_ctrl fpec_flash_ctrl_props u_props (.sys_clk(sys_clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .flashAbort(flashAbort), .cpuStall(cpuStall),
    .flashActive(flashActive), .flashErase(flashErase), .flashOpCode(flashOpCode),
    .flashAddr(flashAddr));

// ### fpec_flash_ctrl_tb.sv
`timescale 1ns/1ps
`include "fpec_defs.vh"
module fpec_flash_ctrl_tb;
    reg sys_clk = 1'h0;
    reg arst_n = 1'h0;
    reg warmRst = 1'h0;
    reg flashAbort = 1'h0;
    reg [2:0] avs_address = 3'h0;
    reg avs_read = 1'h0;
    reg avs_write = 1'h0;
    reg [31:0] avs_writedata = 32'h0;
    reg ce = 1'h1;
    reg [3:0] avs_byteenable = 4'hF;
    reg [7:0] pg = 8'h5A;
    reg [31:0] rd = 32'h0;
    reg [28:0] lat = 29'h0;
    reg stallSeen = 1'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire cpuStall;
    wire flashActive;
    wire flashErase;
    wire [3:0] flashOpCode;
    wire [23:0] flashAddr;
    integer err_total = 0;
    integer checks = 0;
    integer cyc = 0;
    // short cycle counts keep the run brief; each class gets a distinct length
    fpec_flash_ctrl #(.WORD_CYCLES(24'h000004), .ROW_CYCLES(24'h000008),
        .PAGE_CYCLES(24'h00000C), .BULK_CYCLES(24'h000010), .CFG_CYCLES(24'h000014)) dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .warmRst(warmRst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .flashAbort(flashAbort), .cpuStall(cpuStall),
        .flashActive(flashActive), .flashErase(flashErase), .flashOpCode(flashOpCode),
        .flashAddr(flashAddr));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cpuStall === 1'h1)
            stallSeen = 1'h1;
        if (flashActive === 1'h1)
            lat = {flashErase, flashOpCode, flashAddr};
        if (cyc == 6000) begin
            err_total = err_total + 1;
            finish_test;
        end
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // one avalon cycle; held until waitrequest is sampled low, then released
    task bus(input [2:0] a, input wr, input [31:0] d);
        begin
            @(posedge sys_clk);
            avs_address <= a;
            avs_write <= wr;
            avs_read <= !wr;
            avs_writedata <= d;
            do @(posedge sys_clk); while (avs_waitrequest !== 1'h0);
            rd = avs_readdata;
            avs_read <= 1'h0;
            avs_write <= 1'h0;
        end
    endtask
    task unlock;
        begin
            bus(3'h1, 1'h1, 32'h55);
            bus(3'h1, 1'h1, 32'hAA);
        end
    endtask
    // set up, unlock, start, then time the cycle and read back the control word
    task run_op(input [31:0] ctl, input integer n, input flt);
        integer act;
        begin
            act = 0;
            lat = 29'h0;
            bus(3'h0, 1'h1, ctl);
            unlock;
            bus(3'h0, 1'h1, ctl | 32'h8000);
            // nothing else is issued until the whole cycle has run out
            do begin
                @(posedge sys_clk);
                act = act + (flashActive === 1'h1);
            end while (cpuStall === 1'h1);
            chk(act >= n && act <= n + 1, 32'h1);
            if (n > 0)
                chk(lat, {ctl[6], ctl[3:0], pg, 16'h1234});
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, ctl | {flt, 13'h0});
        end
    endtask
    task t_regs;
        begin
            bus(3'h0, 1'h1, 32'hFFFF7FFF);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h604F);
            // low lane only: erase select and code change, allow and fault stay
            avs_byteenable <= 4'h1;
            bus(3'h0, 1'h1, 32'h0);
            avs_byteenable <= 4'hF;
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h6000);
            bus(3'h1, 1'h1, 32'h55);
            bus(3'h1, 1'h0, 32'h0);
            chk(rd, 32'h0);
            bus(3'h5, 1'h0, 32'h0);
            chk(rd, 32'h0);
            bus(3'h2, 1'h1, 32'h5A);
            bus(3'h3, 1'h1, 32'h1234);
        end
    endtask
    task t_ops;
        begin
            run_op(32'h404F, 16, 1'h0);
            run_op(32'h404D, 16, 1'h0);
            run_op(32'h404C, 16, 1'h0);
            run_op(32'h4042, 12, 1'h0);
            run_op(32'h4040, 20, 1'h0);
            run_op(32'h4043, 0, 1'h0);
            run_op(32'h4041, 0, 1'h0);
            run_op(32'h4045, 0, 1'h1);
            run_op(32'h4003, 4, 1'h0);
            run_op(32'h4001, 8, 1'h0);
            // row outside the erased page: page pointer advanced, effective address kept
            bus(3'h2, 1'h1, 32'h5B);
            pg = 8'h5B;
            run_op(32'h4001, 8, 1'h0);
            run_op(32'h4000, 20, 1'h0);
            run_op(32'h400F, 0, 1'h0);
            run_op(32'h400D, 0, 1'h0);
            run_op(32'h400C, 0, 1'h0);
            run_op(32'h4002, 0, 1'h0);
            run_op(32'h4007, 0, 1'h1);
        end
    endtask
    // unarmed, interrupted, disabled and warm-reset starts are all refused
    task t_refuse;
        begin
            stallSeen = 1'h0;
            bus(3'h0, 1'h1, 32'h4042);
            bus(3'h0, 1'h1, 32'hC042);
            bus(3'h1, 1'h1, 32'h55);
            bus(3'h2, 1'h1, 32'h5A);
            bus(3'h1, 1'h1, 32'hAA);
            bus(3'h0, 1'h1, 32'hC042);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h6042);
            bus(3'h0, 1'h1, 32'h0042);
            unlock;
            bus(3'h0, 1'h1, 32'h8042);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h2042);
            bus(3'h0, 1'h1, 32'h4041);
            unlock;
            @(posedge sys_clk);
            warmRst <= 1'h1;
            @(posedge sys_clk);
            warmRst <= 1'h0;
            bus(3'h0, 1'h1, 32'hC041);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h6041);
            chk(stallSeen, 1'h0);
        end
    endtask
    task t_abort;
        begin
            bus(3'h0, 1'h1, 32'h404F);
            unlock;
            bus(3'h0, 1'h1, 32'hC04F);
            bus(3'h0, 1'h1, 32'h404F);
            chk(cpuStall, 1'h1);
            @(posedge sys_clk);
            flashAbort <= 1'h1;
            @(posedge sys_clk);
            flashAbort <= 1'h0;
            repeat (4) @(posedge sys_clk);
            chk(cpuStall, 1'h0);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h604F);
            @(posedge sys_clk);
            arst_n <= 1'h0;
            @(posedge sys_clk);
            arst_n <= 1'h1;
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h0);
        end
    endtask
    // a low clock enable holds a running cycle where it is
    task t_freeze;
        begin
            bus(3'h0, 1'h1, 32'h4003);
            unlock;
            bus(3'h0, 1'h1, 32'hC003);
            @(posedge sys_clk);
            ce <= 1'h0;
            repeat (8) @(posedge sys_clk);
            chk(cpuStall, 1'h1);
            chk(flashActive, 1'h1);
            ce <= 1'h1;
            while (cpuStall !== 1'h0) @(posedge sys_clk);
            bus(3'h0, 1'h0, 32'h0);
            chk(rd, 32'h4003);
        end
    endtask
    task finish_test;
        begin
            $display("checks=%0d err_total=%0d", checks, err_total);
            if (err_total == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'h1;
        t_regs;
        t_ops;
        t_refuse;
        t_abort;
        t_freeze;
        finish_test;
    end
endmodule // fpec_flash_ctrl_tb
